/* File: rtl/ebcr_top.sv */
// ebcr_top: extended bus configuration register with its control outputs.
// assumes the controller core supplies bus-master, mode, link and filter
// status synchronous to aclk; the software reset input is only observed.
//
// Contract
// RULE_01: 16-bit read/write configuration register at index 3fh.
// RULE_02: hardware reset clears all bits; output levels unknown until written.
// RULE_03: software reset leaves every bit of the register unchanged.
// RULE_04: software should write only while the controller is in software reset.
// RULE_05: as bus master, drive four user outputs from bits 15-12.
// RULE_06: user outputs only available when extended bus mode selected.
// RULE_07: bit 11 set ignores heartbeat; clear keeps heartbeat checking.
// RULE_08: bit 9 clear runs jabber timer; set disables it.
// RULE_09: bit 8 picks attachment port only without good twisted-pair link.
// RULE_10: automatic port selection disregards the external port-select pin.
// RULE_11: bit 6 enables transceiver loopback.
// RULE_12: bit 4 delays hold request assertion and release by half clock.
// RULE_13: bit 2 alone asserts compress output on filter address match.
// RULE_14: reserved bits 10, 7, 5, 3 written zero and have no function.
// RULE_15: readback returns the last written value of every defined field.
//
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/1ps
module ebcr_top
   import ebcr_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire ebcr_pkg::ebcr_axi_req_type axi_req,
   output ebcr_pkg::ebcr_axi_rsp_type axi_rsp,
   input wire logic sw_reset,
   input wire logic bus_master,
   input wire logic ext_bus_mode,
   input wire logic tp_link_good,
   input wire logic port_select_pin,
   input wire logic hold_request,
   input wire logic rx_addr_valid,
   input wire logic rx_addr_match,
   output logic [3:0] extended_user_output,
   output logic extended_user_output_oe_n,
   output logic heartbeat_check_en,
   output logic jabber_timer_en,
   output logic aui_selected,
   output logic transceiver_loopback,
   output logic bus_hold_out,
   output logic packet_compress_output,
   output logic reject_on_filter_match
);
   import ebcr_pkg::*;

   // ----------------------------------------------------------------
   // register state
   // ----------------------------------------------------------------
   logic [15:0] cfg_r;
   logic [15:0] cfg_nxt;
   logic aw_held_r;
   logic w_held_r;
   logic [EBCR_ADDR_W-1:0] awaddr_r;
   logic [31:0] wdata_r;
   logic [3:0] wstrb_r;
   logic bvalid_r;
   logic [1:0] bresp_r;
   logic rvalid_r;
   logic [31:0] rdata_r;
   logic [1:0] rresp_r;
   logic [3:0] ext_out_level_r;
   logic ext_drive_r;
   logic aui_sel_r;
   logic hold_q_r;
   logic hold_out_r;
   logic compress_r;
   logic reject_r;

   // ----------------------------------------------------------------
   // bus decode
   // ----------------------------------------------------------------
   wire aw_take = axi_req.awvalid && axi_rsp.awready;
   wire w_take = axi_req.wvalid && axi_rsp.wready;
   wire ar_take = axi_req.arvalid && axi_rsp.arready;
   wire do_write = aw_held_r && w_held_r && !bvalid_r;
   // RULE_01 index decode
   wire wr_cfg = awaddr_r[7:2] == EBCR_CFG_INDEX;
   wire wr_stat = awaddr_r[7:2] == EBCR_STAT_INDEX;
   wire rd_cfg = axi_req.araddr[7:2] == EBCR_CFG_INDEX;
   wire rd_stat = axi_req.araddr[7:2] == EBCR_STAT_INDEX;
   wire [15:0] lane_mask = {{8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
   // RULE_14 reserved bits masked
   wire [15:0] wr_val = wdata_r[15:0] & EBCR_CFG_MASK;
   wire [15:0] stat_val = {11'h000, reject_r, compress_r, bus_hold_out, ext_drive_r, aui_sel_r};
   wire [31:0] rd_val = rd_cfg ? {16'h0000, cfg_r} : (rd_stat ? {16'h0000, stat_val} : 32'h0);

   assign axi_rsp.awready = !aw_held_r && !bvalid_r;
   assign axi_rsp.wready = !w_held_r && !bvalid_r;
   assign axi_rsp.bvalid = bvalid_r;
   assign axi_rsp.bresp = bresp_r;
   assign axi_rsp.arready = !rvalid_r;
   assign axi_rsp.rvalid = rvalid_r;
   assign axi_rsp.rdata = rdata_r;
   assign axi_rsp.rresp = rresp_r;

   // RULE_03 software reset not used here
   // RULE_04 writes accepted in any state, software keeps the order
   assign cfg_nxt = (do_write && wr_cfg) ? ((cfg_r & ~lane_mask) | (wr_val & lane_mask)) : cfg_r;

   // ----------------------------------------------------------------
   // write channel
   // ----------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_r <= 1'b0;
         w_held_r <= 1'b0;
         awaddr_r <= '0;
         wdata_r <= 32'h0;
         wstrb_r <= 4'h0;
      end else begin
         if (aw_take) begin
            aw_held_r <= 1'b1;
            awaddr_r <= axi_req.awaddr;
         end else if (do_write) begin
            aw_held_r <= 1'b0;
         end
         if (w_take) begin
            w_held_r <= 1'b1;
            wdata_r <= axi_req.wdata;
            wstrb_r <= axi_req.wstrb;
         end else if (do_write) begin
            w_held_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_r <= 1'b0;
         bresp_r <= EBCR_RESP_OKAY;
      end else if (do_write) begin
         bvalid_r <= 1'b1;
         bresp_r <= (wr_cfg || wr_stat) ? EBCR_RESP_OKAY : EBCR_RESP_SLVERR;
      end else if (axi_req.bready) begin
         bvalid_r <= 1'b0;
      end
   end

   // RULE_02 hardware reset clears
   // output level bits reset too; zero is one legal unknown value
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cfg_r <= EBCR_CFG_RESET;
      end else begin
         cfg_r <= cfg_nxt;
      end
   end

   // ----------------------------------------------------------------
   // read channel
   // ----------------------------------------------------------------
   // RULE_15 readback of fields
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_r <= 1'b0;
         rdata_r <= 32'h0;
         rresp_r <= EBCR_RESP_OKAY;
      end else if (ar_take) begin
         rvalid_r <= 1'b1;
         rdata_r <= rd_val;
         rresp_r <= (rd_cfg || rd_stat) ? EBCR_RESP_OKAY : EBCR_RESP_SLVERR;
      end else if (axi_req.rready) begin
         rvalid_r <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // control outputs
   // ----------------------------------------------------------------
   // RULE_05 master drives levels
   wire ext_drive_nxt = bus_master && ext_bus_mode;
   // RULE_09 auto port choice
   // RULE_10 pin ignored in auto
   wire aui_nxt = cfg_r[EBCR_AUTO_SELECT] ? !tp_link_good : port_select_pin;
   // RULE_13 compress on match
   wire compress_nxt = (cfg_r[EBCR_COMPRESS_MATCH] && !cfg_r[EBCR_COMPRESS_NOMATCH] && rx_addr_match)
      || (cfg_r[EBCR_COMPRESS_NOMATCH] && !cfg_r[EBCR_COMPRESS_MATCH] && !rx_addr_match);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ext_out_level_r <= 4'h0;
         ext_drive_r <= 1'b0;
         aui_sel_r <= 1'b0;
      end else begin
         ext_out_level_r <= cfg_r[15:EBCR_EXT_OUT_LSB];
         ext_drive_r <= ext_drive_nxt;
         aui_sel_r <= aui_nxt;
      end
   end

   // RULE_12 hold edge delay
   // one aclk stands for the half bus clock; the late edge costs a cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         hold_q_r <= 1'b0;
         hold_out_r <= 1'b0;
      end else begin
         hold_q_r <= hold_request;
         hold_out_r <= cfg_r[EBCR_HOLD_EDGE] ? hold_q_r : hold_request;
      end
   end

   // results stand until the next received address
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         compress_r <= 1'b0;
         reject_r <= 1'b0;
      end else if (rx_addr_valid) begin
         compress_r <= compress_nxt;
         reject_r <= cfg_r[EBCR_REJECT_MATCH] && rx_addr_match;
      end
   end

   // RULE_06 mode gates outputs
   assign extended_user_output = ext_out_level_r;
   assign extended_user_output_oe_n = !ext_drive_r;
   // RULE_07 heartbeat ignore
   assign heartbeat_check_en = !cfg_r[EBCR_HEARTBEAT_IGNORE];
   // RULE_08 jabber timer off
   assign jabber_timer_en = !cfg_r[EBCR_JABBER_TIMER_OFF];
   assign aui_selected = aui_sel_r;
   // RULE_11 loopback enable
   assign transceiver_loopback = cfg_r[EBCR_LOOPBACK];
   assign bus_hold_out = hold_out_r;
   assign packet_compress_output = compress_r;
   assign reject_on_filter_match = reject_r;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   sequence s_cfg_write;
      do_write && wr_cfg && (wstrb_r[1:0] == 2'h3);
   endsequence
   // held write data cannot move while the answer is pending, so $past is safe
   sequence s_value_lands;
      ##1 cfg_r == ($past(wdata_r[15:0]) & EBCR_CFG_MASK);
   endsequence

   property p_write_lands;
      @(posedge aclk) disable iff (!aresetn) s_cfg_write |-> s_value_lands;
   endproperty
   a_write_lands: assert property (p_write_lands) else $error("cfg write lost"); // RULE_15

   property p_reserved_zero;
      @(posedge aclk) disable iff (!aresetn) (cfg_r & ~EBCR_CFG_MASK) == 16'h0000;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set"); // RULE_14

   property p_reset_clear;
      @(posedge aclk) !aresetn |=> cfg_r == 16'h0000;
   endproperty
   a_reset_clear: assert property (p_reset_clear) else $error("cfg not cleared"); // RULE_02

   property p_swreset_keeps;
      @(posedge aclk) disable iff (!aresetn) (sw_reset && !do_write) |=> $stable(cfg_r);
   endproperty
   a_swreset_keeps: assert property (p_swreset_keeps) else $error("cfg changed"); // RULE_03

   property p_ext_drive;
      @(posedge aclk) disable iff (!aresetn)
         (bus_master && ext_bus_mode) |=> !extended_user_output_oe_n
            && extended_user_output == $past(cfg_r[15:12]);
   endproperty
   a_ext_drive: assert property (p_ext_drive) else $error("user outputs wrong"); // RULE_05

   property p_ext_mode_off;
      @(posedge aclk) disable iff (!aresetn) !ext_bus_mode |=> extended_user_output_oe_n;
   endproperty
   a_ext_mode_off: assert property (p_ext_mode_off) else $error("outputs without mode"); // RULE_06

   property p_auto_select;
      @(posedge aclk) disable iff (!aresetn)
         cfg_r[EBCR_AUTO_SELECT] |=> aui_selected == !$past(tp_link_good);
   endproperty
   a_auto_select: assert property (p_auto_select) else $error("auto port wrong"); // RULE_09

   sequence s_late_hold_kept;
      cfg_r[EBCR_HOLD_EDGE] ##1 cfg_r[EBCR_HOLD_EDGE];
   endsequence
   property p_hold_late;
      @(posedge aclk) disable iff (!aresetn)
         s_late_hold_kept |=> bus_hold_out == $past(hold_request, 2);
   endproperty
   a_hold_late: assert property (p_hold_late) else $error("late hold wrong"); // RULE_12

   property p_compress;
      @(posedge aclk) disable iff (!aresetn)
         (rx_addr_valid && rx_addr_match && cfg_r[2:1] == 2'h2) |=> packet_compress_output;
   endproperty
   a_compress: assert property (p_compress) else $error("compress missing"); // RULE_13

   property p_write_answer;
      @(posedge aclk) disable iff (!aresetn) do_write |=> bvalid_r
         && (bresp_r == ($past(wr_cfg || wr_stat) ? EBCR_RESP_OKAY : EBCR_RESP_SLVERR));
   endproperty
   a_write_answer: assert property (p_write_answer) else $error("no write answer"); // RULE_01
endmodule

/* File: common/ebcr_pkg.sv */
// ebcr_pkg: register map, field positions, reset values and bus carriers
// for the extended bus configuration register bank.
// assumes an AXI4-Lite master with 32-bit data and 8-bit byte addresses.
package ebcr_pkg;
   // ----------------------------------------------------------------
   // register map (index = printed offset, byte address = index * 4)
   // ----------------------------------------------------------------
   localparam logic [5:0] EBCR_CFG_INDEX = 6'h3f;
   localparam logic [5:0] EBCR_STAT_INDEX = 6'h3e;
   localparam int EBCR_ADDR_W = 8;
   localparam logic [15:0] EBCR_CFG_RESET = 16'h0000;
   // defined fields; reserved positions 10, 7, 5, 3 read as zero
   localparam logic [15:0] EBCR_CFG_MASK = 16'hfb57;
   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int EBCR_EXT_OUT_LSB = 12;
   localparam int EBCR_HEARTBEAT_IGNORE = 11;
   localparam int EBCR_JABBER_TIMER_OFF = 9;
   localparam int EBCR_AUTO_SELECT = 8;
   localparam int EBCR_LOOPBACK = 6;
   localparam int EBCR_HOLD_EDGE = 4;
   localparam int EBCR_COMPRESS_MATCH = 2;
   localparam int EBCR_COMPRESS_NOMATCH = 1;
   localparam int EBCR_REJECT_MATCH = 0;
   // ----------------------------------------------------------------
   // bus responses
   // ----------------------------------------------------------------
   localparam logic [1:0] EBCR_RESP_OKAY = 2'h0;
   localparam logic [1:0] EBCR_RESP_SLVERR = 2'h2;
   // ----------------------------------------------------------------
   // bus carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic awvalid;
      logic [EBCR_ADDR_W-1:0] awaddr;
      logic wvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bready;
      logic arvalid;
      logic [EBCR_ADDR_W-1:0] araddr;
      logic rready;
   } ebcr_axi_req_type;
   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } ebcr_axi_rsp_type;
endpackage

/* File: verification/ebcr_host_model.sv */
// ebcr_host_model: behavioural AXI4-Lite master standing in for host software.
// assumes each task is entered right after a rising edge of aclk, one at a time.
`timescale 1ns/1ps
module ebcr_host_model
   import ebcr_pkg::*;
(
   input wire logic aclk,
   input wire ebcr_pkg::ebcr_axi_rsp_type axi_rsp,
   output ebcr_pkg::ebcr_axi_req_type axi_req,
   output logic hung
);
   import ebcr_pkg::*;
   initial begin
      axi_req = '0;
      hung = 1'b0;
   end
   // ----------------------------------------------------------------
   // response wait, shared by both directions
   // ----------------------------------------------------------------
   task automatic take(input int n0);
      logic ok;
      int n;
      n = n0;
      do begin
         @(negedge aclk);
         ok = (axi_rsp.bvalid && axi_req.bready) || (axi_rsp.rvalid && axi_req.rready);
         @(posedge aclk);
         n++;
      end while (!ok && n < 128);
      {axi_req.bready, axi_req.rready} <= 2'b00;
      if (!ok) hung = 1'b1;
   endtask
   // ----------------------------------------------------------------
   // transfers; ready is sampled on the falling edge so no race at rise
   // ----------------------------------------------------------------
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
      input int slow);
      logic pa, pw;
      int n;
      {pa, pw} = 2'b11;
      n = 0;
      {axi_req.awvalid, axi_req.awaddr, axi_req.wvalid, axi_req.wdata, axi_req.wstrb} <=
         {1'b1, a, 1'b1, d, s};
      while ((pa || pw) && n < 64) begin
         @(negedge aclk);
         {pa, pw} = {pa && !axi_rsp.awready, pw && !axi_rsp.wready};
         @(posedge aclk);
         n++;
         // released lines must not keep showing the old value
         if (!pa) {axi_req.awvalid, axi_req.awaddr} <= {1'b0, ~a};
         if (!pw) {axi_req.wvalid, axi_req.wdata} <= {1'b0, ~d};
      end
      if (pa || pw) hung = 1'b1;
      repeat (slow) @(posedge aclk);
      axi_req.bready <= 1'b1;
      take(n);
   endtask
   task automatic rd(input logic [7:0] a, input int slow);
      logic pa;
      int n;
      pa = 1'b1;
      n = 0;
      {axi_req.arvalid, axi_req.araddr} <= {1'b1, a};
      while (pa && n < 64) begin
         @(negedge aclk);
         pa = !axi_rsp.arready;
         @(posedge aclk);
         n++;
      end
      if (pa) hung = 1'b1;
      {axi_req.arvalid, axi_req.araddr} <= {1'b0, ~a};
      repeat (slow) @(posedge aclk);
      axi_req.rready <= 1'b1;
      take(n);
   endtask
endmodule

/* File: verification/tb.sv */
// tb: self-checking bench for the extended bus configuration register bank.
// assumes the host model carries all bus traffic; core status comes from here.
`timescale 1ns/1ps
module tb;
   import ebcr_pkg::*;
   logic aclk, aresetn, sw_reset, bus_master, ext_bus_mode, tp_link_good, port_select_pin;
   logic hold_request, rx_addr_valid, rx_addr_match, oe_n, hb_en, jab_en, aui, loopb;
   logic hold_out, comp, rej, hung;
   logic [3:0] ext_out;
   logic [15:0] lfsr_r, cfg;
   logic [33:0] expq[$];
   ebcr_axi_req_type axi_req;
   ebcr_axi_rsp_type axi_rsp;
   int bad_count, checks;
   localparam logic [7:0] CFG_A = {EBCR_CFG_INDEX, 2'h0};
   localparam logic [7:0] STAT_A = {EBCR_STAT_INDEX, 2'h0};
   ebcr_top i_dut (.aclk(aclk), .aresetn(aresetn), .axi_req(axi_req), .axi_rsp(axi_rsp),
      .sw_reset(sw_reset), .bus_master(bus_master), .ext_bus_mode(ext_bus_mode),
      .tp_link_good(tp_link_good), .port_select_pin(port_select_pin),
      .hold_request(hold_request), .rx_addr_valid(rx_addr_valid),
      .rx_addr_match(rx_addr_match), .extended_user_output(ext_out),
      .extended_user_output_oe_n(oe_n), .heartbeat_check_en(hb_en),
      .jabber_timer_en(jab_en), .aui_selected(aui), .transceiver_loopback(loopb),
      .bus_hold_out(hold_out), .packet_compress_output(comp), .reject_on_filter_match(rej));
   ebcr_host_model i_host (.aclk(aclk), .axi_rsp(axi_rsp), .axi_req(axi_req), .hung(hung));
   initial begin
      aclk = 1'b0;
      forever #2.5 aclk = ~aclk;
   end
   function automatic logic [15:0] lfsr(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction
   // ----------------------------------------------------------------
   // compare, verdict, bus wrappers
   // ----------------------------------------------------------------
   task automatic chk(input string nm, input logic [33:0] e, input logic [33:0] g);
      checks++;
      if (g !== e) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic finish_test;
      if (bad_count == 0 && checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic wr(input logic [15:0] d, input logic [3:0] s, input logic [7:0] a,
      input logic [1:0] r);
      expq.push_back({r, 32'h0});
      lfsr_r = lfsr(lfsr_r);
      i_host.wr(a, {lfsr_r, d}, s, int'(lfsr_r[1:0]));
      if (hung) bad_count++;
      if (hung) finish_test();
   endtask
   task automatic rd(input logic [7:0] a, input logic [33:0] e);
      expq.push_back(e);
      lfsr_r = lfsr(lfsr_r);
      i_host.rd(a, int'(lfsr_r[2:1]));
      if (hung) bad_count++;
      if (hung) finish_test();
   endtask
   task automatic setcfg(input logic [15:0] v);
      sw_reset <= 1'b1;
      wr(v, 4'hf, CFG_A, EBCR_RESP_OKAY);
      cfg = v;
   endtask
   // results are taken off the queue as the bus answers appear
   always @(negedge aclk) begin
      if (axi_rsp.rvalid && axi_req.rready)
         chk("read", expq.pop_front(), {axi_rsp.rresp, axi_rsp.rdata});
      if (axi_rsp.bvalid && axi_req.bready)
         chk("bresp", expq.pop_front(), {axi_rsp.bresp, 32'h0});
   end
   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      aresetn = 1'b0;
      {sw_reset, bus_master, ext_bus_mode, tp_link_good, port_select_pin} = '0;
      {hold_request, rx_addr_valid, rx_addr_match} = '0;
      {bad_count, checks} = '0;
      lfsr_r = 16'h0049;
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd(CFG_A, {EBCR_RESP_OKAY, 32'h0});
      @(negedge aclk);
      chk("hb_jab_oe", 34'h7, {31'h0, hb_en, jab_en, oe_n});
      @(posedge aclk);
      for (int i = 0; i < 6; i++) begin
         lfsr_r = lfsr(lfsr_r);
         // reserved bits zero and never both compress bits
         setcfg(lfsr_r & EBCR_CFG_MASK & ~{14'h0, lfsr_r[2], 1'b0});
         rd(CFG_A, {EBCR_RESP_OKAY, 16'h0, cfg});
         @(negedge aclk);
         chk("ctl", {31'h0, ~cfg[11], ~cfg[9], cfg[6]}, {31'h0, hb_en, jab_en, loopb});
         @(posedge aclk);
      end
      sw_reset <= 1'b0;
      repeat (3) @(posedge aclk);
      rd(CFG_A, {EBCR_RESP_OKAY, 16'h0, cfg});
      sw_reset <= 1'b1;
      wr(16'hffff, 4'h2, CFG_A, EBCR_RESP_OKAY);
      rd(CFG_A, {EBCR_RESP_OKAY, 16'h0, 8'hfb, cfg[7:0]});
      wr(16'h1234, 4'hf, 8'h40, EBCR_RESP_SLVERR);
      rd(8'h40, {EBCR_RESP_SLVERR, 32'h0});
      setcfg(16'ha100);
      bus_master <= 1'b1;
      repeat (3) @(posedge aclk);
      @(negedge aclk);
      chk("oe_n", 34'h1, {33'h0, oe_n});
      @(posedge aclk);
      ext_bus_mode <= 1'b1;
      repeat (2) @(posedge aclk);
      @(negedge aclk);
      chk("ext_out", 34'ha, {29'h0, oe_n, ext_out});
      for (int i = 0; i < 8; i++) begin
         @(posedge aclk);
         if (i == 4) setcfg(16'h0010);
         {tp_link_good, port_select_pin} <= i[1:0];
         repeat (2) @(posedge aclk);
         @(negedge aclk);
         chk("aui", {33'h0, cfg[8] ? ~i[1] : i[0]}, {33'h0, aui});
      end
      @(posedge aclk);
      for (int h = 0; h < 2; h++) begin
         setcfg({11'h0, h[0], 4'h0});
         hold_request <= 1'b1;
         @(posedge aclk);
         @(negedge aclk);
         chk("hold_a", {33'h0, ~h[0]}, {33'h0, hold_out});
         @(negedge aclk);
         chk("hold_b", 34'h1, {33'h0, hold_out});
         @(posedge aclk);
         hold_request <= 1'b0;
         repeat (3) @(posedge aclk);
      end
      setcfg(16'h0005);
      for (int m = 0; m < 2; m++) begin
         {rx_addr_valid, rx_addr_match} <= {1'b1, m[0]};
         @(posedge aclk);
         rx_addr_valid <= 1'b0;
         @(negedge aclk);
         chk("cmp_rej", {32'h0, m[0], m[0]}, {32'h0, comp, rej});
         @(posedge aclk);
      end
      // status: reject, compress, no hold, drive on, port pin high
      rd(STAT_A, {EBCR_RESP_OKAY, 32'h0000001b});
      // second hardware reset in mid-run must clear the programmed value
      aresetn <= 1'b0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd(CFG_A, {EBCR_RESP_OKAY, 32'h0});
      finish_test();
   end
endmodule
